// file: vcm_cfg.svh
`ifndef VCM_CFG_SVH
`define VCM_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define VCM_ADDR_W 16
`define VCM_REG_APP_MODE 16'h0200
`define VCM_REG_DECIM 16'h0201

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define VCM_MODE_LSB 0
`define VCM_MODE_W 4
`define VCM_QIGN_BIT 5
`define VCM_DECIM_LSB 0
`define VCM_DECIM_W 4

// ----------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------
`define VCM_MODE_FULL 4'h0
`define VCM_MODE_ONE 4'h1
`define VCM_MODE_TWO 4'h2
`define VCM_MODE_FOUR 4'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define VCM_MODE_RST 4'h0
`define VCM_QIGN_RST 1'b0
`define VCM_DECIM_RST 4'h1

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define VCM_SLOTS 8
`define VCM_DDCS 4
`define VCM_SAMPLE_W 16
`define VCM_FIFO_DEPTH 8

`endif

// file: vcm_pkg.sv
`default_nettype none
`include "vcm_cfg.svh"

package vcm_pkg;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef logic [`VCM_SAMPLE_W-1:0] vcm_sample_type;

  // All input streams of one sample instant travel together.
  typedef struct packed {
    vcm_sample_type adcA;
    vcm_sample_type adcB;
    vcm_sample_type [`VCM_DDCS-1:0] ddcI;
    vcm_sample_type [`VCM_DDCS-1:0] ddcQ;
  } vcm_streams_type;

  // One output frame: eight slots and a mask of those in use.
  typedef struct packed {
    logic [`VCM_SLOTS-1:0] active;
    vcm_sample_type [`VCM_SLOTS-1:0] slot;
  } vcm_frame_type;

  // Register access port.
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [`VCM_ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } vcm_reg_req_type;

endpackage

`default_nettype wire

// file: vcm_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module vcm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic inValid, // Write request.
  output logic inReady, // Room for a word.
  input wire logic [WIDTH-1:0] inData, // Write data.
  output logic outValid, // Output word present.
  input wire logic outReady, // Consumer takes the word.
  output logic [WIDTH-1:0] outData // Output word.
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic [PW:0] count_d;
  logic inReady_q;
  logic outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic push;
  logic pop;

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  // The output register refills whenever it is empty or being drained.
  assign push = inValid && inReady_q;
  assign pop = (count_q != '0) && (!outValid_q || outReady);
  assign count_d = count_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outData = outData_q;

  // Storage; pointers wrap naturally, so DEPTH must be a power of two.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady_q <= 1'b0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_d;
      inReady_q <= (count_d < (PW+1)'(DEPTH));
    end
  end

  // Registered read port.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (pop) begin
      outValid_q <= 1'b1;
      outData_q <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

endmodule // vcm_fifo

`default_nettype wire

// file: virtual_converter_mapper.sv
// Operation
// RULE1: Mode field picks full, one, two, four.
// RULE2: Q-ignore bit picks real or complex.
// RULE3: Full bandwidth: A to slot 0, B 1.
// RULE4: Downconverter modes enable one, two, four channels.
// RULE5: Output rate is input rate over ratio.
// RULE6: Each I or Q stream is a converter.
// RULE7: Up to eight slots; count follows config.
// RULE8: Complex pairs adjacent; real I at slot k.
// RULE9: Same count for digital or analog I/Q.
// RULE10: Fixed slots only while swapping is off.
// RULE11: Unused slots carry zero, not counted active.
// RULE12: Software configures before link, matches count.
`include "vcm_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module virtual_converter_mapper
  import vcm_pkg::*;
#(
  parameter int FIFO_DEPTH = `VCM_FIFO_DEPTH
) (
  input wire logic core_clk, // Sample clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire vcm_reg_req_type regReq, // Register access request.
  output logic [7:0] regRdata, // Register read data.
  input wire logic channelSwap, // Swap enable for slot pairs.
  input wire logic sampleValid, // Input streams valid.
  output logic sampleReady, // Block can take a sample.
  input wire vcm_streams_type samples, // Converter and DDC streams.
  output logic frameValid, // Frame for the transport layer.
  input wire logic frameReady, // Transport layer takes frame.
  output vcm_frame_type frameData, // Slots and active mask.
  output logic [3:0] activeCount, // Converters in use.
  output logic [`VCM_SLOTS-1:0] activeMask // Slots in use.
);

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [`VCM_MODE_W-1:0] appMode_q;
  logic qIgnore_q;
  logic [`VCM_DECIM_W-1:0] decimRatio_q;
  logic [7:0] regRdata_q;

  // Only the defined fields are stored; reserved bits read back as zero.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      appMode_q <= `VCM_MODE_RST;
      qIgnore_q <= `VCM_QIGN_RST;
    end else if (regReq.wrEn && regReq.addr == `VCM_REG_APP_MODE) begin
      appMode_q <= regReq.wdata[`VCM_MODE_LSB +: `VCM_MODE_W]; // RULE1
      qIgnore_q <= regReq.wdata[`VCM_QIGN_BIT]; // RULE2
    end
  end

  // Decimation ratio field.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      decimRatio_q <= `VCM_DECIM_RST;
    end else if (regReq.wrEn && regReq.addr == `VCM_REG_DECIM) begin
      decimRatio_q <= regReq.wdata[`VCM_DECIM_LSB +: `VCM_DECIM_W]; // RULE5
    end
  end

  // Read data is registered one cycle after the request; unmapped reads give zero.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata_q <= 8'h00;
    end else if (regReq.rdEn) begin
      regRdata_q <= 8'h00;
      if (regReq.addr == `VCM_REG_APP_MODE) begin
        regRdata_q[`VCM_MODE_LSB +: `VCM_MODE_W] <= appMode_q;
        regRdata_q[`VCM_QIGN_BIT] <= qIgnore_q;
      end else if (regReq.addr == `VCM_REG_DECIM) begin
        regRdata_q[`VCM_DECIM_LSB +: `VCM_DECIM_W] <= decimRatio_q;
      end
    end
  end

  assign regRdata = regRdata_q;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  logic fullBw;
  logic [2:0] ddcCount;
  logic [3:0] count_d;

  // Codes above four downconverters are not defined; they enable no slot
  // rather than guess at a mapping the receiver cannot expect.
  always_comb begin
    fullBw = 1'b0;
    ddcCount = 3'd0;
    unique case (appMode_q)
      `VCM_MODE_FULL: fullBw = 1'b1; // RULE1 RULE3
      `VCM_MODE_ONE: ddcCount = 3'd1; // RULE4
      `VCM_MODE_TWO: ddcCount = 3'd2; // RULE4
      `VCM_MODE_FOUR: ddcCount = 3'd4; // RULE4
      default: ddcCount = 3'd0;
    endcase
  end

  // Converter count: the same figure serves a digital or an analog I/Q
  // source, since both present one I and one Q stream.
  always_comb begin
    if (fullBw) begin
      count_d = qIgnore_q ? 4'd1 : 4'd2; // RULE7
    end else if (qIgnore_q) begin
      count_d = {1'b0, ddcCount}; // RULE6 RULE7
    end else begin
      count_d = {ddcCount, 1'b0}; // RULE6 RULE7 RULE9
    end
  end

  // ----------------------------------------------------------------------
  // Slot mapping
  // ----------------------------------------------------------------------
  // A net, not a variable: every slot of the loop drives its own bits.
  wire vcm_frame_type frame;

  genvar s;
  generate
    for (s = 0; s < `VCM_SLOTS; s++) begin : g_slot
      localparam int K = s / 2;
      localparam bit ODD = (s % 2) == 1;
      logic cplxOn;
      logic realOn;
      logic fullOn;
      vcm_sample_type cplxVal;
      vcm_sample_type realVal;
      vcm_sample_type fullVal;

      // Complex: I of channel K in the even slot, Q in the odd one.
      // Swapping exchanges the two halves of the pair.
      assign cplxOn = !fullBw && !qIgnore_q && (K < ddcCount); // RULE8
      assign cplxVal = (ODD ^ channelSwap) ? samples.ddcQ[K]
                                            : samples.ddcI[K]; // RULE8 RULE10

      // Real: I of channel s in slot s; the upper half stays unused.
      if (s < `VCM_DDCS) begin : g_real
        assign realOn = !fullBw && qIgnore_q && (s < ddcCount); // RULE8
        assign realVal = samples.ddcI[s];
      end else begin : g_noreal
        assign realOn = 1'b0;
        assign realVal = '0;
      end

      // Full bandwidth: converter A in slot 0, B in slot 1.
      if (s == 0) begin : g_full0
        assign fullOn = fullBw; // RULE3
        assign fullVal = channelSwap ? samples.adcB : samples.adcA; // RULE3 RULE10
      end else if (s == 1) begin : g_full1
        assign fullOn = fullBw && !qIgnore_q; // RULE3
        assign fullVal = channelSwap ? samples.adcA : samples.adcB; // RULE3 RULE10
      end else begin : g_fulln
        assign fullOn = 1'b0;
        assign fullVal = '0;
      end

      // Unused slots are forced to zero and left out of the mask.
      assign frame.active[s] = cplxOn || realOn || fullOn; // RULE11
      assign frame.slot[s] = fullOn ? fullVal :
                             cplxOn ? cplxVal :
                             realOn ? realVal : '0; // RULE11
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Decimation
  // ----------------------------------------------------------------------
  logic [`VCM_DECIM_W-1:0] decimCnt_q;
  logic [`VCM_DECIM_W-1:0] ratioLast;
  logic fifoInReady;
  logic accept;
  logic decimHit;
  logic push;

  // A ratio of zero is treated as one, so the output never stops.
  // The compare uses >= so a ratio lowered mid-count ends at once.
  assign ratioLast = (decimRatio_q == '0) ? '0 : decimRatio_q - 1'b1;
  assign accept = sampleValid && fifoInReady;
  assign decimHit = (decimCnt_q >= ratioLast);
  assign push = accept && decimHit; // RULE5

  // Counts accepted input samples; one frame leaves per ratio samples.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      decimCnt_q <= '0;
    end else if (accept) begin
      decimCnt_q <= decimHit ? '0 : decimCnt_q + 1'b1; // RULE5
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  logic [3:0] activeCount_q;
  logic [`VCM_SLOTS-1:0] activeMask_q;

  // The count shown here is what the link's converter count must match.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      activeCount_q <= 4'h0;
      activeMask_q <= '0;
    end else begin
      activeCount_q <= count_d; // RULE7 RULE12
      activeMask_q <= frame.active; // RULE11
    end
  end

  assign activeCount = activeCount_q;
  assign activeMask = activeMask_q;
  assign sampleReady = fifoInReady;

  // ----------------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------------
  // The buffer absorbs transport stalls; when it fills, sampleReady drops
  // and the decimation counter holds, so no input sample is skipped.
  vcm_fifo #(
    .WIDTH($bits(vcm_frame_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .inValid(push),
    .inReady(fifoInReady),
    .inData(frame),
    .outValid(frameValid),
    .outReady(frameReady),
    .outData(frameData)
  );

endmodule // virtual_converter_mapper

`default_nettype wire

// file: vcm_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "vcm_cfg.svh"
module vcm_checker
  import vcm_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset_n, // Reset, active low.
  input wire vcm_reg_req_type regReq, // Register request.
  input wire logic [7:0] regRdata, // Read data.
  input wire logic sampleReady, // Input ready.
  input wire logic frameValid, // Frame present.
  input wire logic frameReady, // Frame taken.
  input wire vcm_frame_type frameData, // Frame.
  input wire logic [3:0] activeCount, // Converters in use.
  input wire logic [`VCM_SLOTS-1:0] activeMask // Slots in use.
);
  // ----
  // Helpers
  // ----
  // Data in an unused slot would look like a live converter downstream.
  logic leak;
  always_comb begin
    leak = 1'b0;
    for (int i = 0; i < `VCM_SLOTS; i++) begin
      if (!frameData.active[i] && frameData.slot[i] != '0) leak = 1'b1;
    end
  end
  wire logic mapped = regReq.addr == `VCM_REG_APP_MODE || regReq.addr == `VCM_REG_DECIM;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Assertions
  // ----
  chk_count_mask: assert property ($countones(activeMask) == activeCount)
    else $error("Mask and count disagree.");
  chk_mask_shape: assert property (activeMask inside {8'h00, 8'h01, 8'h03, 8'h0f, 8'hff})
    else $error("Slots not packed from zero.");
  chk_unused_zero: assert property (frameValid |-> !leak)
    else $error("Unused slot carries data.");
  chk_frame_hold: assert property (frameValid && !frameReady |=> frameValid && $stable(frameData))
    else $error("Frame dropped while stalled.");
  chk_bad_read: assert property (regReq.rdEn && !mapped |=> regRdata == 8'h00)
    else $error("Unmapped read not zero.");
  chk_decim_rsvd: assert property (regReq.rdEn && regReq.addr == `VCM_REG_DECIM |=> regRdata[7:4] == 4'h0)
    else $error("Ratio reserved bits set.");
  chk_rdata_hold: assert property (!regReq.rdEn |=> $stable(regRdata))
    else $error("Read data moved without a read.");
  chk_four_cplx: assert property (regReq.wrEn && regReq.addr == `VCM_REG_APP_MODE &&
    regReq.wdata == 8'h03 ##1 !regReq.wrEn |=> activeCount == 4'h8)
    else $error("Four complex not eight slots.");
  chk_full_slots: assert property (regReq.wrEn && regReq.addr == `VCM_REG_APP_MODE &&
    regReq.wdata == 8'h00 ##1 !regReq.wrEn |=> activeMask == 8'h03)
    else $error("Full bandwidth mask wrong.");
  cov_taken: cover property (frameValid && frameReady);
  cov_eight: cover property (activeCount == 4'h8);
  cov_full: cover property (!sampleReady);
endmodule // vcm_checker
bind virtual_converter_mapper vcm_checker chk (.core_clk, .reset_n, .regReq, .regRdata,
  .sampleReady, .frameValid, .frameReady, .frameData, .activeCount, .activeMask);
`default_nettype wire

// file: vcm_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
module vcm_rx_model
  import vcm_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic stall, // Hold off the mapper.
  input wire logic frameValid, // Frame offered.
  output logic frameReady, // Frame accepted.
  input wire vcm_frame_type frameData // Frame contents.
);
  vcm_frame_type got[$];
  logic rdy = 1'b0;
  // Ready moves off the sampling edge so the handshake never races.
  always @(negedge core_clk) rdy <= !stall;
  assign frameReady = rdy;
  // A frame is delivered at the edge where both halves are high.
  always @(posedge core_clk) begin
    if (frameValid && frameReady) got.push_back(frameData);
  end
endmodule // vcm_rx_model
`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "vcm_cfg.svh"
module tb
  import vcm_pkg::*;
;
  localparam int DEPTH = 4;
  localparam logic [15:0] AM = `VCM_REG_APP_MODE;
  localparam logic [15:0] DR = `VCM_REG_DECIM;
  logic core_clk = 1'b0, reset_n = 1'b0, channelSwap = 1'b0, sampleValid = 1'b0, stall = 1'b0;
  vcm_reg_req_type regReq = '0;
  vcm_streams_type smp = '0;
  logic [7:0] regRdata, activeMask;
  logic sampleReady, frameValid, frameReady;
  logic [3:0] activeCount;
  vcm_frame_type frameData;
  int err_total = 0, n_tests = 0;
  `define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH %0t %s", $time, m); end end
  initial forever #5 core_clk = ~core_clk;
  virtual_converter_mapper #(.FIFO_DEPTH(DEPTH)) DUT (.core_clk, .reset_n, .regReq, .regRdata,
    .channelSwap, .sampleValid, .sampleReady, .samples(smp), .frameValid, .frameReady,
    .frameData, .activeCount, .activeMask);
  vcm_rx_model rx (.core_clk, .stall, .frameValid, .frameReady, .frameData);
  // ----
  // Bus and stream tasks
  // ----
  task summarize;
    if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regReq.wrEn = 1'b1; regReq.addr = a; regReq.wdata = d;
    @(negedge core_clk);
    regReq.wrEn = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regReq.rdEn = 1'b1; regReq.addr = a;
    @(negedge core_clk);
    regReq.rdEn = 1'b0;
    @(negedge core_clk);
    d = regRdata;
  endtask
  // A sample is only offered once ready is seen, so none is lost.
  task automatic push(input logic [15:0] v);
    int i;
    @(negedge core_clk);
    smp.adcA = v;
    for (i = 0; i < 50 && sampleReady !== 1'b1; i++) @(negedge core_clk);
    if (i == 50) begin `CHK(1'b0, 1'b1, "ready timeout") summarize; end
    sampleValid = 1'b1;
    @(negedge core_clk);
    sampleValid = 1'b0;
  endtask
  task automatic frames(input int n);
    int i;
    for (i = 0; i < 100 && rx.got.size() < n; i++) @(negedge core_clk);
    if (i == 100) begin `CHK(1'b0, 1'b1, "frame timeout") summarize; end
  endtask
  function automatic vcm_frame_type expf(logic [7:0] c, logic sw);
    vcm_frame_type f;
    int n;
    f = '0;
    n = c[3:0] == `VCM_MODE_ONE ? 1 : c[3:0] == `VCM_MODE_TWO ? 2 : c[3:0] == `VCM_MODE_FOUR ? 4 : 0;
    if (c[3:0] == `VCM_MODE_FULL) begin
      f.active[1:0] = c[5] ? 2'b01 : 2'b11;
      f.slot[0] = sw ? smp.adcB : smp.adcA;
      if (!c[5]) f.slot[1] = sw ? smp.adcA : smp.adcB;
    end
    for (int k = 0; k < n; k++) begin
      if (c[5]) begin
        f.active[k] = 1'b1;
        f.slot[k] = smp.ddcI[k];
      end else begin
        f.active[2*k+:2] = 2'b11;
        f.slot[2*k] = sw ? smp.ddcQ[k] : smp.ddcI[k];
        f.slot[2*k+1] = sw ? smp.ddcI[k] : smp.ddcQ[k];
      end
    end
    return f;
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    logic [7:0] d;
    rd(AM, d); `CHK(d, 8'h00, "mode reset")
    rd(DR, d); `CHK(d, 8'h01, "ratio reset")
    wr(AM, 8'h23); rd(AM, d); `CHK(d, 8'h23, "mode rw")
    wr(16'h0300, 8'h5a); rd(16'h0300, d); `CHK(d, 8'h00, "unmapped")
    rd(AM, d); `CHK(d, 8'h23, "alias")
    wr(DR, 8'hff); rd(DR, d); `CHK(d, 8'h0f, "ratio field")
    wr(DR, 8'h01);
  endtask
  task automatic t_modes;
    logic [7:0] cfg[8] = '{8'h00, 8'h20, 8'h01, 8'h21, 8'h02, 8'h22, 8'h03, 8'h23};
    vcm_frame_type f;
    for (int i = 0; i < 8; i++) begin
      wr(AM, cfg[i]);
      f = expf(cfg[i], 1'b0);
      repeat (2) @(negedge core_clk);
      `CHK(activeMask, f.active, "mask")
      `CHK(activeCount, 4'($countones(f.active)), "count")
      rx.got.delete();
      push(16'h0a00 + 16'(i));
      frames(1);
      `CHK(rx.got[0], expf(cfg[i], 1'b0), "frame")
    end
    wr(AM, 8'h04);
    repeat (2) @(negedge core_clk);
    `CHK(activeMask, 8'h00, "bad mode")
  endtask
  task automatic t_swap;
    logic [7:0] cfg[3] = '{8'h00, 8'h01, 8'h03};
    channelSwap = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(AM, cfg[i]);
      rx.got.delete();
      push(16'h0d00 + 16'(i));
      frames(1);
      `CHK(rx.got[0], expf(cfg[i], 1'b1), "swap frame")
    end
    channelSwap = 1'b0;
  endtask
  task automatic t_decim;
    wr(AM, 8'h00);
    wr(DR, 8'h03);
    rx.got.delete();
    for (int i = 0; i < 6; i++) push(16'h0b00 + 16'(i));
    repeat (20) @(negedge core_clk);
    `CHK(rx.got.size(), 2, "decimated count")
    wr(DR, 8'h01);
  endtask
  // Fill with the receiver stalled, then drain and check order.
  task automatic t_fifo;
    int n;
    n = 0;
    stall = 1'b1;
    rx.got.delete();
    repeat (4) @(negedge core_clk);
    while (n < 20 && sampleReady === 1'b1) begin
      push(16'h0c00 + 16'(n));
      n++;
    end
    `CHK(n, DEPTH + 1, "capacity")
    stall = 1'b0;
    frames(n);
    for (int k = 0; k < n; k++) `CHK(rx.got[k].slot[0], 16'h0c00 + 16'(k), "order")
  endtask
  initial begin
    for (int k = 0; k < `VCM_DDCS; k++) begin
      smp.ddcI[k] = 16'h1000 + 16'(k);
      smp.ddcQ[k] = 16'h2000 + 16'(k);
    end
    smp.adcB = 16'hbb00;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_regs;
    t_modes;
    t_swap;
    t_decim;
    t_fifo;
    summarize;
  end
endmodule // tb
`default_nettype wire
